// [src/nand_host_map.svh]
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

// ==========================================================
// Command codes
`define CMD_READ_SETUP   8'h00
`define CMD_READ_START   8'h30
`define CMD_COL_SETUP    8'h05
`define CMD_COL_START    8'he0
`define CMD_PROG_SETUP   8'h80
`define CMD_PROG_START   8'h10
`define CMD_ERASE_SETUP  8'h60
`define CMD_ERASE_START  8'hd0
`define CMD_STATUS       8'h70
`define CMD_ID           8'h90
`define CMD_RESET        8'hff

// ==========================================================
// Geometry
`define PAGE_BYTES       2112
`define MAIN_BYTES       2048
`define SPARE_BYTES      64
`define PAGES_PER_BLOCK  64
`define BLOCK_COUNT      2048
`define COL_W            12
`define ROW_W            17
`define PAGE_IDX_W       6
`define ADDR_CYCLES_FULL 5
`define ADDR_CYCLES_COL  2
`define ADDR_CYCLES_ROW  3
`define ADDR_FIRST_ROW   2
`define ADDR_IDX_ID      5

// ==========================================================
// Timing
`define CLK_NS           10
`define T_RP_NS          35
`define T_RHW_NS         30
`define T_WB_NS          200
`define T_RR_NS          20
`define STROBE_LOW_CYC   ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_HIGH_CYC  ((`T_RHW_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_CYC           ((`T_WB_NS + `CLK_NS - 1) / `CLK_NS)
`define RR_CYC           ((`T_RR_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [src/nand_host_pkg.sv]
package nand_host_pkg;

  // ==========================================================
  // Operations offered on the user port
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_COLCHG = 3'h1,
    OP_PROG   = 3'h2,
    OP_ERASE  = 3'h3,
    OP_STATUS = 3'h4,
    OP_ID     = 3'h5,
    OP_RESET  = 3'h6
  } op_t;

  typedef struct packed {
    op_t          op;
    logic [16:0]  row_bits;
    logic [11:0]  column_bits;
    logic [11:0]  len;
  } req_t;

  typedef struct packed {
    logic       chip_select_n;
    logic       command_latch_en;
    logic       address_latch_en;
    logic       write_strobe_n;
    logic       output_strobe_n;
    logic       protect_n;
    logic       io_oe;
    logic [7:0] io_out;
  } pins_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD1 = 8'h02,
    ST_ADDR = 8'h04,
    ST_DIN  = 8'h08,
    ST_CMD2 = 8'h10,
    ST_WAIT = 8'h20,
    ST_DOUT = 8'h40,
    ST_DONE = 8'h80
  } state_t;

endpackage : nand_host_pkg

// [src/nand_host.sv]
`timescale 1ns/1ns
`include "nand_host_map.svh"
// Notes on behaviour
// - busy_flag_n is open drain; system pull-up makes ready read high.
// - Address cycle 1 column bits 0-7; cycle 2 bits 8-11, upper lines low.
// - Cycles 3,4 row bits 0-15; cycle 5 row bit 16, other lines low.
// - Write strobe rise latches command, address or data by the latch enables.
// - Read is 00h, full address, then 30h.
// - 05h, new column, e0h during output resumes output at new column.
// - Program is 80, address, data bytes, then 10h.
// - Erase is 60h, address, then d0; erase starts on confirm strobe.
module nand_host #(
  parameter int DATA_W = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire nand_host_pkg::req_t   req,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire logic [DATA_W-1:0]     din_data,
  input  wire logic                  din_valid,
  output logic                       din_ready,
  output logic [DATA_W-1:0]          dout_data,
  output logic                       dout_valid,
  input  wire logic                  dout_ready,
  output logic                       done,
  output nand_host_pkg::pins_t       pins,
  input  wire logic [7:0]            io_in,
  input  wire logic                  busy_flag_n
);

  localparam logic [2:0] LOW_CYC  = 3'(`STROBE_LOW_CYC);
  localparam logic [2:0] LAST_PH  = 3'(`STROBE_LOW_CYC + `STROBE_HIGH_CYC - 1);
  localparam logic [5:0] WB_CYC   = 6'(`WB_CYC);
  localparam logic [5:0] READY_AT = 6'(`WB_CYC + `RR_CYC);

  nand_host_pkg::state_t state_reg;
  nand_host_pkg::req_t   req_reg;
  nand_host_pkg::pins_t  pins_reg;
  logic [2:0]            phase_reg;
  logic [2:0]            aidx_reg;
  logic [2:0]            acnt_reg;
  logic [11:0]           bcnt_reg;
  logic [5:0]            wait_reg;
  logic                  loaded_reg;
  logic [7:0]            wbyte_reg;
  logic                  din_ready_reg;
  logic                  req_ready_reg;
  logic                  done_reg;
  logic [DATA_W-1:0]     out_data_reg;
  logic                  out_valid_reg;
  logic [DATA_W-1:0]     spare_data_reg;
  logic                  spare_valid_reg;
  logic                  go;
  logic                  xfer_end;
  logic                  sample;
  logic                  room;

  // ==========================================================
  // Decoding helpers
  function automatic logic [7:0] first_cmd(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ:   first_cmd = `CMD_READ_SETUP;
      nand_host_pkg::OP_COLCHG: first_cmd = `CMD_COL_SETUP;
      nand_host_pkg::OP_PROG:   first_cmd = `CMD_PROG_SETUP;
      nand_host_pkg::OP_ERASE:  first_cmd = `CMD_ERASE_SETUP;
      nand_host_pkg::OP_STATUS: first_cmd = `CMD_STATUS;
      nand_host_pkg::OP_ID:     first_cmd = `CMD_ID;
      default:                  first_cmd = `CMD_RESET;
    endcase
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ:   second_cmd = `CMD_READ_START;
      nand_host_pkg::OP_COLCHG: second_cmd = `CMD_COL_START;
      nand_host_pkg::OP_PROG:   second_cmd = `CMD_PROG_START;
      default:                  second_cmd = `CMD_ERASE_START;
    endcase
  endfunction : second_cmd

  function automatic logic [2:0] addr_cycles(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ,
      nand_host_pkg::OP_PROG:   addr_cycles = 3'(`ADDR_CYCLES_FULL);
      nand_host_pkg::OP_COLCHG: addr_cycles = 3'(`ADDR_CYCLES_COL);
      nand_host_pkg::OP_ERASE:  addr_cycles = 3'(`ADDR_CYCLES_ROW);
      nand_host_pkg::OP_ID:     addr_cycles = 3'h1;
      default:                  addr_cycles = 3'h0;
    endcase
  endfunction : addr_cycles

  function automatic logic [2:0] addr_first(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_ERASE: addr_first = 3'(`ADDR_FIRST_ROW); // Block erase sends row only
      nand_host_pkg::OP_ID:    addr_first = 3'(`ADDR_IDX_ID);
      default:                 addr_first = 3'h0;
    endcase
  endfunction : addr_first

  function automatic logic [7:0] addr_byte(input logic [2:0] i, input nand_host_pkg::req_t r);
    case (i)
      3'h0:    addr_byte = r.column_bits[7:0];
      3'h1:    addr_byte = {4'h0, r.column_bits[11:8]};
      3'h2:    addr_byte = r.row_bits[7:0];
      3'h3:    addr_byte = r.row_bits[15:8];
      3'h4:    addr_byte = {7'h00, r.row_bits[16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  function automatic logic reads_back(input nand_host_pkg::op_t op);
    reads_back = (op == nand_host_pkg::OP_READ) || (op == nand_host_pkg::OP_COLCHG) ||
                 (op == nand_host_pkg::OP_STATUS) || (op == nand_host_pkg::OP_ID);
  endfunction : reads_back

  // ==========================================================
  // Strobe phase
  // A data write cycle waits at phase 0 for its byte, a read cycle for buffer room
  assign room     = !spare_valid_reg;
  assign go       = (phase_reg != 3'h0) ||
                    (state_reg == nand_host_pkg::ST_DIN  ? loaded_reg :
                     state_reg == nand_host_pkg::ST_DOUT ? room : 1'b1);
  assign xfer_end = (phase_reg == LAST_PH);
  assign sample   = (state_reg == nand_host_pkg::ST_DOUT) && (phase_reg == LOW_CYC);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_reg <= 3'h0;
    end else if (state_reg == nand_host_pkg::ST_IDLE || state_reg == nand_host_pkg::ST_WAIT ||
                 state_reg == nand_host_pkg::ST_DONE || xfer_end) begin
      phase_reg <= 3'h0;
    end else if (go) begin
      phase_reg <= phase_reg + 3'h1;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= nand_host_pkg::ST_IDLE;
      req_reg   <= '0;
      aidx_reg  <= 3'h0;
      acnt_reg  <= 3'h0;
      bcnt_reg  <= 12'h000;
      wait_reg  <= 6'h00;
    end else begin
      case (state_reg)
        nand_host_pkg::ST_IDLE: begin
          if (req_valid && req_ready_reg) begin
            req_reg   <= req;
            aidx_reg  <= addr_first(req.op);
            acnt_reg  <= addr_cycles(req.op);
            bcnt_reg  <= req.len;
            state_reg <= nand_host_pkg::ST_CMD1;
          end
        end
        nand_host_pkg::ST_CMD1: begin
          wait_reg <= 6'h00;
          if (xfer_end) begin
            state_reg <= (acnt_reg != 3'h0) ? nand_host_pkg::ST_ADDR : nand_host_pkg::ST_WAIT;
          end
        end
        nand_host_pkg::ST_ADDR: begin
          wait_reg <= 6'h00;
          if (xfer_end) begin
            aidx_reg <= aidx_reg + 3'h1;
            acnt_reg <= acnt_reg - 3'h1;
            if (acnt_reg == 3'h1) begin
              case (req_reg.op)
                nand_host_pkg::OP_PROG: state_reg <= (req_reg.len == 12'h000) ?
                                                     nand_host_pkg::ST_CMD2 : nand_host_pkg::ST_DIN;
                nand_host_pkg::OP_ID:   state_reg <= nand_host_pkg::ST_WAIT;
                default:                state_reg <= nand_host_pkg::ST_CMD2;
              endcase
            end
          end
        end
        nand_host_pkg::ST_DIN: begin
          if (xfer_end) begin
            bcnt_reg <= bcnt_reg - 12'h001;
            if (bcnt_reg == 12'h001) begin
              state_reg <= nand_host_pkg::ST_CMD2;
            end
          end
        end
        nand_host_pkg::ST_CMD2: begin
          wait_reg <= 6'h00;
          if (xfer_end) begin
            state_reg <= nand_host_pkg::ST_WAIT;
          end
        end
        nand_host_pkg::ST_WAIT: begin
          // Skip tWB before trusting the busy line, then hold off tRR after ready
          if (wait_reg < WB_CYC || busy_flag_n) begin
            wait_reg <= wait_reg + 6'h01;
          end
          if (wait_reg == READY_AT) begin
            bcnt_reg  <= req_reg.len;
            state_reg <= (reads_back(req_reg.op) && req_reg.len != 12'h000) ?
                         nand_host_pkg::ST_DOUT : nand_host_pkg::ST_DONE;
          end
        end
        nand_host_pkg::ST_DOUT: begin
          if (xfer_end) begin
            bcnt_reg <= bcnt_reg - 12'h001;
            if (bcnt_reg == 12'h001) begin
              state_reg <= nand_host_pkg::ST_DONE;
            end
          end
        end
        nand_host_pkg::ST_DONE: begin
          state_reg <= nand_host_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= nand_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Write data intake
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loaded_reg    <= 1'b0;
      wbyte_reg     <= 8'h00;
      din_ready_reg <= 1'b0;
    end else begin
      if (din_valid && din_ready_reg) begin
        loaded_reg <= 1'b1;
        wbyte_reg  <= din_data[7:0];
      end else if (state_reg == nand_host_pkg::ST_DIN && xfer_end) begin
        loaded_reg <= 1'b0;
      end
      din_ready_reg <= (state_reg == nand_host_pkg::ST_DIN) && !loaded_reg &&
                       !(din_valid && din_ready_reg);
    end
  end

  // ==========================================================
  // Pin drive
  // Pins are registered, so each lags the phase by one edge; hold times come from the high phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_reg               <= '0;
      pins_reg.chip_select_n <= 1'b1;
      pins_reg.write_strobe_n  <= 1'b1;
      pins_reg.output_strobe_n <= 1'b1;
    end else begin
      // Select held through the busy wait so standby never starts mid operation
      pins_reg.chip_select_n    <= (state_reg == nand_host_pkg::ST_IDLE) ||
                                   (state_reg == nand_host_pkg::ST_DONE);
      pins_reg.command_latch_en <= (state_reg == nand_host_pkg::ST_CMD1) ||
                                   (state_reg == nand_host_pkg::ST_CMD2);
      pins_reg.address_latch_en <= (state_reg == nand_host_pkg::ST_ADDR);
      pins_reg.write_strobe_n   <= !(go && phase_reg < LOW_CYC &&
                                     (state_reg == nand_host_pkg::ST_CMD1 ||
                                      state_reg == nand_host_pkg::ST_ADDR ||
                                      state_reg == nand_host_pkg::ST_DIN  ||
                                      state_reg == nand_host_pkg::ST_CMD2));
      pins_reg.output_strobe_n  <= !(go && phase_reg < LOW_CYC &&
                                     state_reg == nand_host_pkg::ST_DOUT);
      // Protect released only for program and erase, so stray cycles cannot alter the array
      pins_reg.protect_n        <= (state_reg != nand_host_pkg::ST_IDLE) &&
                                   (req_reg.op == nand_host_pkg::OP_PROG ||
                                    req_reg.op == nand_host_pkg::OP_ERASE);
      pins_reg.io_oe            <= (state_reg == nand_host_pkg::ST_CMD1) ||
                                   (state_reg == nand_host_pkg::ST_ADDR) ||
                                   (state_reg == nand_host_pkg::ST_DIN)  ||
                                   (state_reg == nand_host_pkg::ST_CMD2);
      case (state_reg)
        nand_host_pkg::ST_CMD1: pins_reg.io_out <= first_cmd(req_reg.op);
        nand_host_pkg::ST_ADDR: pins_reg.io_out <= addr_byte(aidx_reg, req_reg);
        nand_host_pkg::ST_DIN:  pins_reg.io_out <= wbyte_reg;
        nand_host_pkg::ST_CMD2: pins_reg.io_out <= second_cmd(req_reg.op);
        default:                pins_reg.io_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Two-entry read buffer
  // Second slot absorbs the byte in flight when the user stalls
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid_reg   <= 1'b0;
      out_data_reg    <= '0;
      spare_valid_reg <= 1'b0;
      spare_data_reg  <= '0;
    end else begin
      if (!out_valid_reg || dout_ready) begin
        if (spare_valid_reg) begin
          out_data_reg    <= spare_data_reg;
          out_valid_reg   <= 1'b1;
          spare_valid_reg <= sample;
          spare_data_reg  <= DATA_W'(io_in);
        end else begin
          out_valid_reg <= sample;
          out_data_reg  <= DATA_W'(io_in);
        end
      end else if (sample) begin
        spare_valid_reg <= 1'b1;
        spare_data_reg  <= DATA_W'(io_in);
      end
    end
  end

  // ==========================================================
  // User handshakes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_ready_reg <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      req_ready_reg <= (state_reg == nand_host_pkg::ST_IDLE) && !(req_valid && req_ready_reg);
      done_reg      <= (state_reg == nand_host_pkg::ST_DONE);
    end
  end

  assign req_ready  = req_ready_reg;
  assign din_ready  = din_ready_reg;
  assign dout_data  = out_data_reg;
  assign dout_valid = out_valid_reg;
  assign done       = done_reg;
  assign pins       = pins_reg;

endmodule : nand_host

// [testbench/nand_host_props.sv]
`timescale 1ns/1ns
module nand_host_props (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire nand_host_pkg::pins_t pins,
  input wire logic                 busy_flag_n
);
  // ==========================================
  // Strobe tracking
  logic       we_q;
  logic       rise;
  logic [7:0] last_cmd;
  logic [2:0] aidx;
  assign rise = pins.write_strobe_n & ~we_q;
  always_ff @(posedge clock) begin
    if (!rst_n) we_q <= 1'b1;
    else we_q <= pins.write_strobe_n;
  end
  // Erase sends row bytes only, so its count starts at the row slot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_cmd <= 8'h00;
      aidx     <= 3'h0;
    end else if (rise && pins.command_latch_en) begin
      last_cmd <= pins.io_out;
      aidx     <= (pins.io_out == 8'h60) ? 3'h2 : 3'h0;
    end else if (rise && pins.address_latch_en) begin
      aidx <= aidx + 3'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  cmd_latch_a: assert property (rise && pins.command_latch_en |->
    !pins.address_latch_en && !pins.chip_select_n && pins.output_strobe_n) else $error("bad command enables");
  data_protect_a: assert property (rise && !pins.command_latch_en && !pins.address_latch_en |->
    pins.protect_n) else $error("data latched while protected");
  bus_hold_a: assert property (!pins.write_strobe_n |=> $stable(pins.io_out) &&
    $stable(pins.command_latch_en) && $stable(pins.address_latch_en)) else $error("bus moved under strobe");
  no_contention_a: assert property (!pins.output_strobe_n |->
    !pins.io_oe && pins.write_strobe_n && !pins.chip_select_n) else $error("host drives during output");
  ready_gap_a: assert property ($fell(pins.output_strobe_n) |->
    busy_flag_n && $past(busy_flag_n) && $past(busy_flag_n, 2)) else $error("output strobe while busy");
  addr_upper_a: assert property (rise && pins.address_latch_en && (aidx == 3'h1 || aidx == 3'h4) |->
    pins.io_out[7:4] == 4'h0 && (aidx == 3'h1 || pins.io_out[3:1] == 3'h0)) else $error("upper lines not low");
  cmd_order_a: assert property (rise && pins.command_latch_en && pins.io_out inside {8'h30, 8'h10, 8'hd0, 8'he0} |->
    last_cmd == (pins.io_out == 8'h30 ? 8'h00 : pins.io_out == 8'h10 ? 8'h80 :
    pins.io_out == 8'hd0 ? 8'h60 : 8'h05)) else $error("confirm without its setup");
  busy_select_a: assert property ($fell(busy_flag_n) |-> !pins.chip_select_n)
    else $error("busy began while deselected");
endmodule : nand_host_props
bind nand_host nand_host_props u_props (.clock(clock), .rst_n(rst_n), .pins(pins), .busy_flag_n(busy_flag_n));

// [testbench/nand_flash_model.sv]
`timescale 1ns/1ns
module nand_flash_model #(
  parameter int         BUSY_NS   = 400,
  parameter logic [7:0] MAKER_ID  = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'ha6  // Arbitrary value
) (
  input  wire nand_host_pkg::pins_t pins,
  output logic [7:0]                dev_data,
  output logic                      dev_oe,
  output logic                      busy_pd
);
  // ==========================================
  // Sparse array, absent entries read erased
  logic [7:0]  mem [int];
  logic [7:0]  page [0:2111];
  logic [7:0]  cmd = 8'h00;
  logic [16:0] row = 17'h00000;
  logic [11:0] col = 12'h000;
  logic        fail = 1'b0;
  int          aidx = 0;
  initial dev_data = 8'h00;
  initial busy_pd = 1'b0;
  assign dev_oe = !pins.chip_select_n && !pins.output_strobe_n && pins.write_strobe_n && !busy_pd;
  always @(posedge pins.write_strobe_n) begin
    if (!pins.chip_select_n && pins.output_strobe_n) begin
      if (pins.command_latch_en && !pins.address_latch_en) begin
        if (!busy_pd || pins.io_out inside {8'h70, 8'hff}) begin
          cmd = pins.io_out;
          aidx = (cmd == 8'h60) ? 2 : 0;
          if (cmd == 8'h90) col = 12'h000;
          for (int c = 0; c < 2112; c++) begin
            if (cmd == 8'h80) page[c] = 8'hff;
            if (cmd == 8'h30) page[c] = mem.exists({row, c[11:0]}) ? mem[{row, c[11:0]}] : 8'hff;
            if (cmd == 8'h10 && pins.protect_n) mem[{row, c[11:0]}] = page[c];
            for (int p = 0; p < 64; p++) begin
              if (cmd == 8'hd0 && pins.protect_n) mem.delete({row[16:6], p[5:0], c[11:0]});
            end
          end
          // Busy is not cut short by deselect
          if (cmd inside {8'h30, 8'h10, 8'hd0, 8'hff}) begin
            busy_pd <= 1'b1;
            busy_pd <= #(BUSY_NS) 1'b0;
          end
        end
      end else if (pins.address_latch_en && !pins.command_latch_en) begin
        case (aidx)
          0: col[7:0] = pins.io_out;
          1: col[11:8] = pins.io_out[3:0];
          2: row[7:0] = pins.io_out;
          3: row[15:8] = pins.io_out;
          default: row[16] = pins.io_out[0];
        endcase
        aidx++;
      end else if (!pins.command_latch_en && pins.protect_n) begin
        page[col] = pins.io_out;
        col++;
      end
    end
  end
  always @(negedge pins.output_strobe_n) begin
    if (!pins.chip_select_n) begin
      if (cmd == 8'h70) dev_data = {pins.protect_n, ~busy_pd, ~busy_pd, 4'h0, fail};
      else if (cmd == 8'h90) dev_data = (col == 12'h000) ? MAKER_ID : DEVICE_ID;
      else dev_data = page[col];
      col++;
    end
  end
endmodule : nand_flash_model

// [testbench/test_nand_host.sv]
`timescale 1ns/1ns
module test_nand_host;
  localparam logic [7:0]  MAKER = 8'h5a;  // Arbitrary value
  localparam logic [7:0]  DEVICE = 8'ha6; // Arbitrary value
  localparam logic [16:0] ROW_A = 17'h00a47;
  localparam logic [16:0] ROW_B = 17'h10a47;
  logic                 clock = 1'b0;
  logic                 rst_n = 1'b0;
  nand_host_pkg::req_t  req = '0;
  logic                 req_valid = 1'b0;
  logic                 req_ready;
  logic [7:0]           din_data = 8'h00;
  logic                 din_valid = 1'b0;
  logic                 din_ready;
  logic [7:0]           dout_data;
  logic                 dout_valid;
  logic                 dout_ready = 1'b1;
  logic                 done;
  nand_host_pkg::pins_t pins;
  logic [7:0]           io_in;
  logic                 busy_flag_n;
  logic [7:0]           dev_data;
  logic                 dev_oe;
  logic                 busy_pd;
  logic [7:0]           wq [$];
  logic [7:0]           rq [$];
  int                   err_total = 0;
  int                   n_tests = 0;
  // ==========================================
  // Harness
  always #5 clock = ~clock;
  // Released lines read back inverted so stale bytes never match
  assign io_in = pins.io_oe ? pins.io_out : (dev_oe ? dev_data : ~dev_data);
  assign busy_flag_n = busy_pd ? 1'b0 : 1'b1;
  nand_host #(.DATA_W(8)) dut (.clock(clock), .rst_n(rst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .din_data(din_data), .din_valid(din_valid), .din_ready(din_ready),
    .dout_data(dout_data), .dout_valid(dout_valid), .dout_ready(dout_ready), .done(done),
    .pins(pins), .io_in(io_in), .busy_flag_n(busy_flag_n));
  nand_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) flash (.pins(pins), .dev_data(dev_data),
    .dev_oe(dev_oe), .busy_pd(busy_pd));
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    n_tests++;
    if (seen !== expected) begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
      err_total++;
    end
  endtask : check
  // Stall holds dout_ready low for that many cycles to fill the buffer
  task automatic run_op(input nand_host_pkg::op_t op, input logic [16:0] row, input logic [11:0] col,
                        input logic [11:0] len, input int stall);
    logic fin;
    int   rd;
    fin = 1'b0;
    rd = (op inside {nand_host_pkg::OP_PROG, nand_host_pkg::OP_ERASE, nand_host_pkg::OP_RESET}) ? 0 : int'(len);
    rq = {};
    @(posedge clock);
    req <= '{op: op, row_bits: row, column_bits: col, len: len};
    req_valid <= 1'b1;
    for (int i = 0; i < 20000 && !(fin && rq.size() >= rd); i++) begin
      @(posedge clock);
      if (req_valid && req_ready) req_valid <= 1'b0;
      if (din_valid && din_ready) void'(wq.pop_front());
      din_valid <= wq.size() != 0;
      din_data <= (wq.size() != 0) ? wq[0] : 8'h00;
      if (dout_valid && dout_ready) rq.push_back(dout_data);
      dout_ready <= i >= stall;
      if (done) fin = 1'b1;
    end
    if (!(fin && rq.size() >= rd)) begin
      err_total++;
      stop_test();
    end
  endtask : run_op
  task automatic t_program();
    wq = {8'h11, 8'h22, 8'h33, 8'h44};
    run_op(nand_host_pkg::OP_PROG, ROW_A, 12'h83c, 12'h004, 0);
    check(8'(wq.size()), 8'h00);
    run_op(nand_host_pkg::OP_STATUS, ROW_A, 12'h000, 12'h001, 0);
    check(rq[0], 8'h60);
    wq = {8'h55, 8'h66};
    run_op(nand_host_pkg::OP_PROG, ROW_B, 12'h83c, 12'h002, 0);
  endtask : t_program
  task automatic t_read_stall();
    run_op(nand_host_pkg::OP_READ, ROW_A, 12'h83c, 12'h004, 250);
    check(8'(rq.size()), 8'h04);
    for (int i = 0; i < 4; i++) check(rq[i], 8'h11 * 8'(i + 1));
  endtask : t_read_stall
  task automatic t_col_change();
    run_op(nand_host_pkg::OP_READ, ROW_B, 12'h83c, 12'h001, 0);
    check(rq[0], 8'h55);
    run_op(nand_host_pkg::OP_COLCHG, ROW_B, 12'h83d, 12'h001, 0);
    check(rq[0], 8'h66);
  endtask : t_col_change
  // Erase addresses another page of the same block
  task automatic t_erase();
    run_op(nand_host_pkg::OP_ERASE, ROW_A ^ 17'h0003f, 12'h000, 12'h000, 0);
    run_op(nand_host_pkg::OP_READ, ROW_A, 12'h83c, 12'h002, 0);
    check(rq[0], 8'hff);
    check(rq[1], 8'hff);
    run_op(nand_host_pkg::OP_READ, ROW_B, 12'h83c, 12'h001, 0);
    check(rq[0], 8'h55);
    run_op(nand_host_pkg::OP_STATUS, ROW_A, 12'h000, 12'h001, 0);
    check(rq[0], 8'h60);
  endtask : t_erase
  task automatic t_ident();
    run_op(nand_host_pkg::OP_RESET, ROW_A, 12'h000, 12'h000, 0);
    run_op(nand_host_pkg::OP_ID, ROW_A, 12'h000, 12'h002, 0);
    check(rq[0], MAKER);
    check(rq[1], DEVICE);
  endtask : t_ident
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_program();
    t_read_stall();
    t_col_change();
    t_erase();
    t_ident();
    stop_test();
  end
endmodule : test_nand_host
